// ---- verilog/sfrc_read_engine.sv ----
// Read command front end: link-side sequencer plus core-side settings
`timescale 1ns/100ps
module sfrc_read_engine (
  input  wire logic                              clk,
  input  wire logic                              resetn,
  input  wire logic                              array_busy,
  input  wire logic                              quad_enable_bit,
  input  wire logic                              four_lane_command_mode,
  input  wire logic                              wrap_load,
  input  wire sfrc_pkg::sfrc_wrap_t              wrap_wdata,
  input  wire logic                              dummy_load,
  input  wire logic [1:0]                        dummy_wdata,
  output sfrc_pkg::sfrc_wrap_t                   wrap_setting_bits,
  output logic [1:0]                             dummy_field,
  output logic                                   continuous_read_active,
  output logic                                   read_active,
  input  wire logic                              sck,
  input  wire logic                              cs_n,
  input  wire logic [3:0]                        data_lane_i,
  output logic [3:0]                             data_lane_o,
  output logic [3:0]                             data_lane_oe,
  output logic [sfrc_pkg::ADDR_W-1:0]            mem_addr,
  input  wire logic [7:0]                        mem_rdata
);

  // ----------------------------------------------------------------------
  // Core-side settings and crossings
  // ----------------------------------------------------------------------
  sfrc_pkg::sfrc_wrap_t           wrap_q;
  logic [1:0]                     dfield_q;
  sfrc_pkg::sfrc_cfg_t            cfg_src_q;
  logic [1:0]                     stat_s1_q;
  logic [1:0]                     stat_s2_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wrap_q   <= sfrc_pkg::WRAP_RST;
      dfield_q <= sfrc_pkg::DFIELD_RST;
    end else begin
      if (wrap_load) begin
        wrap_q <= wrap_wdata;
      end
      if (dummy_load) begin
        dfield_q <= dummy_wdata;
      end
    end
  end

  // Registered so the link side never sees a combinational glitch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_src_q <= '0;
    end else begin
      cfg_src_q <= '{busy: array_busy, quad_enable_bit: quad_enable_bit,
                     four_lane_command_mode: four_lane_command_mode,
                     wrap: wrap_q, dummy_field: dfield_q};
    end
  end

  logic                           crm_q;
  sfrc_pkg::sfrc_lane_drv_t       drv_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stat_s1_q <= 2'h0;
      stat_s2_q <= 2'h0;
    end else begin
      stat_s1_q <= {crm_q, drv_q.oe[1]};
      stat_s2_q <= stat_s1_q;
    end
  end

  assign wrap_setting_bits      = wrap_q;
  assign dummy_field            = dfield_q;
  assign continuous_read_active = stat_s2_q[1];
  assign read_active            = stat_s2_q[0];

  // ----------------------------------------------------------------------
  // Link-side synchronisers
  // ----------------------------------------------------------------------
  // Word taken only when two synchronised samples agree; host idles four clocks
  sfrc_pkg::sfrc_cfg_t            cfg_s1_q;
  sfrc_pkg::sfrc_cfg_t            cfg_s2_q;
  sfrc_pkg::sfrc_cfg_t            cfg_s3_q;
  sfrc_pkg::sfrc_cfg_t            cfg;
  logic [1:0]                     rst_s_q;

  always_ff @(posedge sck) begin
    cfg_s1_q <= cfg_src_q;
    cfg_s2_q <= cfg_s1_q;
    cfg_s3_q <= cfg_s2_q;
    if (cfg_s3_q == cfg_s2_q) cfg <= cfg_s3_q;
    rst_s_q  <= {rst_s_q[0], resetn};
  end

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic [4:0] phase_len(sfrc_pkg::sfrc_phase_t ph, logic [7:0] op,
                                           logic fl, logic [1:0] df);
    logic [4:0] dq;
    dq = (df == sfrc_pkg::DFIELD_RST) ? sfrc_pkg::DUMMY_4 :
         (df == sfrc_pkg::DFIELD_6)   ? sfrc_pkg::DUMMY_6 : sfrc_pkg::DUMMY_8;
    phase_len = 5'h00;
    case (ph)
      sfrc_pkg::S_CMD: phase_len = fl ? sfrc_pkg::CMD_CLKS_FL : sfrc_pkg::CMD_CLKS_SPI;
      sfrc_pkg::S_ADDR: begin
        if (op == sfrc_pkg::OP_DUAL_IO) phase_len = sfrc_pkg::ADDR_CLKS_2;
        else if (op == sfrc_pkg::OP_QUAD_IO || fl) phase_len = sfrc_pkg::ADDR_CLKS_4;
        else phase_len = sfrc_pkg::ADDR_CLKS_1;
      end
      sfrc_pkg::S_MODE: begin
        if (op == sfrc_pkg::OP_DUAL_IO) phase_len = sfrc_pkg::MODE_CLKS_2L;
        else if (op == sfrc_pkg::OP_QUAD_IO) phase_len = sfrc_pkg::MODE_CLKS_4L;
      end
      sfrc_pkg::S_DUMMY: begin
        case (op)
          sfrc_pkg::OP_FAST:     phase_len = fl ? dq : sfrc_pkg::DUMMY_SPI;
          sfrc_pkg::OP_DUAL_OUT,
          sfrc_pkg::OP_QUAD_OUT: phase_len = sfrc_pkg::DUMMY_SPI;
          sfrc_pkg::OP_QUAD_IO:
            phase_len = fl ? dq - sfrc_pkg::MODE_IN_DUMMY : sfrc_pkg::DUMMY_QIO_SPI;
          default:               phase_len = 5'h00;
        endcase
      end
      default: phase_len = 5'h00;
    endcase
  endfunction

  function automatic logic op_ok(logic [7:0] op, logic fl, logic qen);
    if (fl) begin
      op_ok = (op == sfrc_pkg::OP_FAST) || (op == sfrc_pkg::OP_QUAD_IO && qen);
    end else begin
      op_ok = (op == sfrc_pkg::OP_READ) || (op == sfrc_pkg::OP_FAST) ||
              (op == sfrc_pkg::OP_DUAL_OUT) || (op == sfrc_pkg::OP_DUAL_IO) ||
              ((op == sfrc_pkg::OP_QUAD_OUT || op == sfrc_pkg::OP_QUAD_IO) && qen);
    end
  endfunction

  // Lane code: 0 one lane, 1 two lanes, 2 four lanes
  function automatic logic [1:0] out_code(logic [7:0] op, logic fl);
    if (fl || op == sfrc_pkg::OP_QUAD_OUT || op == sfrc_pkg::OP_QUAD_IO) out_code = 2'h2;
    else if (op == sfrc_pkg::OP_DUAL_OUT || op == sfrc_pkg::OP_DUAL_IO) out_code = 2'h1;
    else out_code = 2'h0;
  endfunction

  function automatic sfrc_pkg::sfrc_lane_drv_t lane_drive(logic [7:0] b, logic [1:0] oc);
    sfrc_pkg::sfrc_lane_drv_t d;
    case (oc)
      2'h0:    d = '{o: {2'h0, b[7], 1'h0}, oe: 4'h2};
      2'h1:    d = '{o: {2'h0, b[7:6]},     oe: 4'h3};
      default: d = '{o: b[7:4],             oe: 4'hF};
    endcase
    lane_drive = d;
  endfunction

  // ----------------------------------------------------------------------
  // Frame sequencer on the rising edge
  // ----------------------------------------------------------------------
  sfrc_pkg::sfrc_phase_t          st_q;
  sfrc_pkg::sfrc_phase_t          st_d;
  sfrc_pkg::sfrc_phase_t          cur;
  logic [4:0]                     cnt_q;
  logic [4:0]                     cnt_d;
  logic [7:0]                     cmd_q;
  logic [23:0]                    sh_q;
  logic [23:0]                    sh_d;
  logic [23:0]                    addr_q;
  logic [1:0]                     in_code;
  logic                           fl;
  logic                           ph_last;

  assign fl  = cfg.four_lane_command_mode;
  // A frame opens in the address phase while continuous-read mode holds
  assign cur = (st_q == sfrc_pkg::S_IDLE) ?
               (crm_q ? sfrc_pkg::S_ADDR : sfrc_pkg::S_CMD) : st_q;

  assign in_code = (cur == sfrc_pkg::S_CMD) ? (fl ? 2'h2 : 2'h0) :
                   (fl || cmd_q == sfrc_pkg::OP_QUAD_IO) ? 2'h2 :
                   (cmd_q == sfrc_pkg::OP_DUAL_IO) ? 2'h1 : 2'h0;

  always_comb begin
    case (in_code)
      2'h0:    sh_d = {sh_q[22:0], data_lane_i[0]};
      2'h1:    sh_d = {sh_q[21:0], data_lane_i[1:0]};
      default: sh_d = {sh_q[19:0], data_lane_i};
    endcase
  end

  assign ph_last = (cnt_q == phase_len(cur, cmd_q, fl, cfg.dummy_field) - 5'h01);

  always_comb begin
    st_d  = cur;
    cnt_d = cnt_q + 5'h01;
    unique case (cur)
      sfrc_pkg::S_IDLE, sfrc_pkg::S_DATA, sfrc_pkg::S_IGNORE: begin
        cnt_d = cnt_q;
      end
      sfrc_pkg::S_CMD: begin
        if (ph_last) begin
          cnt_d = 5'h00;
          st_d  = (cfg.busy || !op_ok(sh_d[7:0], fl, cfg.quad_enable_bit)) ?
                  sfrc_pkg::S_IGNORE : sfrc_pkg::S_ADDR;
        end
      end
      sfrc_pkg::S_ADDR: begin
        if (st_q == sfrc_pkg::S_IDLE && cfg.busy) begin
          st_d = sfrc_pkg::S_IGNORE;
        end else if (ph_last) begin
          cnt_d = 5'h00;
          if (phase_len(sfrc_pkg::S_MODE, cmd_q, fl, cfg.dummy_field) != 5'h00)
            st_d = sfrc_pkg::S_MODE;
          else if (phase_len(sfrc_pkg::S_DUMMY, cmd_q, fl, cfg.dummy_field) != 5'h00)
            st_d = sfrc_pkg::S_DUMMY;
          else
            st_d = sfrc_pkg::S_DATA;
        end
      end
      sfrc_pkg::S_MODE: begin
        if (ph_last) begin
          cnt_d = 5'h00;
          st_d  = (phase_len(sfrc_pkg::S_DUMMY, cmd_q, fl, cfg.dummy_field) != 5'h00) ?
                  sfrc_pkg::S_DUMMY : sfrc_pkg::S_DATA;
        end
      end
      sfrc_pkg::S_DUMMY: begin
        if (ph_last) begin
          cnt_d = 5'h00;
          st_d  = sfrc_pkg::S_DATA;
        end
      end
    endcase
  end

  // Chip select high clears the frame without needing a clock edge
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      st_q  <= sfrc_pkg::S_IDLE;
      cnt_q <= 5'h00;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      sh_q   <= 24'h000000;
      addr_q <= 24'h000000;
    end else begin
      sh_q <= sh_d;
      if (cur == sfrc_pkg::S_ADDR && ph_last) begin
        addr_q <= sh_d;
      end
    end
  end

  // Survives chip select and soft reset; cleared by the core reset or by mode bits other than 10
  always_ff @(posedge sck) begin
    if (!rst_s_q[1]) begin
      crm_q <= 1'h0;
      cmd_q <= sfrc_pkg::OP_READ;
    end else begin
      if (cur == sfrc_pkg::S_CMD && st_d == sfrc_pkg::S_ADDR) begin
        cmd_q <= sh_d[7:0];
      end
      if (cur == sfrc_pkg::S_MODE && ph_last) begin
        crm_q <= (sh_d[5:4] == sfrc_pkg::CRM_ENTER);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Data output on the falling edge
  // ----------------------------------------------------------------------
  logic [7:0]                     sr_q;
  logic [2:0]                     nb_q;
  logic                           first_q;
  logic [23:0]                    rd_addr_q;
  logic [23:0]                    wmask;
  logic [23:0]                    addr_inc;
  logic [23:0]                    next_addr;
  logic [1:0]                     oc;
  logic [2:0]                     step;
  logic                           wrap_on;
  logic                           load;

  assign oc       = out_code(cmd_q, fl);
  assign step     = 3'h1 << oc;
  assign load     = (st_q == sfrc_pkg::S_DATA) && (nb_q == 3'h0);
  assign mem_addr = first_q ? addr_q : rd_addr_q;
  assign wmask    = (24'h000008 << cfg.wrap.wrap_length_field) - 24'h000001;
  assign wrap_on  = !cfg.wrap.wrap_disable_bit && cmd_q == sfrc_pkg::OP_QUAD_IO &&
                    !fl;
  assign addr_inc = mem_addr + 24'h000001;
  // Whole-array reads roll over at the top address
  assign next_addr = wrap_on ? ((mem_addr & ~wmask) | (addr_inc & wmask)) :
                     addr_inc;

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      drv_q     <= '0;
      sr_q      <= 8'h00;
      nb_q      <= 3'h0;
      first_q   <= 1'h1;
      rd_addr_q <= 24'h000000;
    end else if (st_q != sfrc_pkg::S_DATA) begin
      drv_q   <= '0;
      nb_q    <= 3'h0;
      first_q <= 1'h1;
    end else if (nb_q == 3'h0) begin
      drv_q     <= lane_drive(mem_rdata, oc);
      sr_q      <= mem_rdata << step;
      nb_q      <= sfrc_pkg::NB_TOP >> oc;
      rd_addr_q <= next_addr;
      first_q   <= 1'h0;
    end else begin
      drv_q <= lane_drive(sr_q, oc);
      sr_q  <= sr_q << step;
      nb_q  <= nb_q - 3'h1;
    end
  end

  assign data_lane_o  = drv_q.o;
  assign data_lane_oe = drv_q.oe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic cmd_end;
  logic addr_end;
  assign cmd_end  = (cur == sfrc_pkg::S_CMD) && ph_last;
  assign addr_end = (cur == sfrc_pkg::S_ADDR) && ph_last && !fl;

  busy_ignore_a: assert property (@(posedge sck) disable iff (cs_n)
    (cmd_end && cfg.busy) |=> st_q == sfrc_pkg::S_IGNORE [*3])
    else $error("read taken while busy");
  quad_out_gate_a: assert property (@(posedge sck) disable iff (cs_n)
    (cmd_end && sh_d[7:0] == sfrc_pkg::OP_QUAD_OUT && !cfg.quad_enable_bit)
    |=> st_q == sfrc_pkg::S_IGNORE) else $error("quad output read taken without enable");
  quad_io_gate_a: assert property (@(posedge sck) disable iff (cs_n)
    (cmd_end && sh_d[7:0] == sfrc_pkg::OP_QUAD_IO && !cfg.quad_enable_bit)
    |=> st_q == sfrc_pkg::S_IGNORE) else $error("quad io read taken without enable");
  fast_dummy_a: assert property (@(posedge sck) disable iff (cs_n)
    (addr_end && cmd_q == sfrc_pkg::OP_FAST) |=>
    st_q == sfrc_pkg::S_DUMMY [*8] ##1 st_q == sfrc_pkg::S_DATA)
    else $error("fast read dummy count wrong");
  dual_out_dummy_a: assert property (@(posedge sck) disable iff (cs_n)
    (addr_end && cmd_q == sfrc_pkg::OP_DUAL_OUT) |=>
    st_q == sfrc_pkg::S_DUMMY [*8] ##1 st_q == sfrc_pkg::S_DATA)
    else $error("dual output dummy count wrong");
  quad_out_dummy_a: assert property (@(posedge sck) disable iff (cs_n)
    (addr_end && cmd_q == sfrc_pkg::OP_QUAD_OUT) |=>
    st_q == sfrc_pkg::S_DUMMY [*8] ##1 st_q == sfrc_pkg::S_DATA)
    else $error("quad output dummy count wrong");
  dual_io_mode_a: assert property (@(posedge sck) disable iff (cs_n)
    (addr_end && cmd_q == sfrc_pkg::OP_DUAL_IO) |=>
    st_q == sfrc_pkg::S_MODE [*4] ##1 st_q == sfrc_pkg::S_DATA)
    else $error("dual io mode timing wrong");
  quad_io_spi_a: assert property (@(posedge sck) disable iff (cs_n)
    (addr_end && cmd_q == sfrc_pkg::OP_QUAD_IO) |=> st_q == sfrc_pkg::S_MODE [*2]
    ##1 st_q == sfrc_pkg::S_DUMMY [*4] ##1 st_q == sfrc_pkg::S_DATA)
    else $error("quad io single-lane timing wrong");
  quad_io_fl_a: assert property (@(posedge sck) disable iff (cs_n)
    ((cur == sfrc_pkg::S_ADDR) && ph_last && fl && cmd_q == sfrc_pkg::OP_QUAD_IO &&
     cfg.dummy_field == sfrc_pkg::DFIELD_RST) |=>
    st_q == sfrc_pkg::S_MODE [*2] ##1 st_q == sfrc_pkg::S_DATA)
    else $error("four-lane quad io default timing wrong");
  crm_mode_a: assert property (@(posedge sck) disable iff (cs_n)
    ((cur == sfrc_pkg::S_MODE) && ph_last) |=> crm_q == ($past(sh_d[5:4]) == 2'h2))
    else $error("continuous mode not following mode bits");
  crm_skip_a: assert property (@(posedge sck) disable iff (cs_n)
    (st_q == sfrc_pkg::S_IDLE && crm_q && !cfg.busy) |=> st_q == sfrc_pkg::S_ADDR)
    else $error("opcode expected in continuous mode");
  oe_data_a: assert property (@(negedge sck) disable iff (cs_n)
    (data_lane_oe != 4'h0) |-> $past(st_q) == sfrc_pkg::S_DATA)
    else $error("lanes driven outside data phase");
  addr_inc_a: assert property (@(negedge sck) disable iff (cs_n)
    (load && !wrap_on) |=> rd_addr_q == $past(mem_addr) + 24'h000001)
    else $error("read address not incremented");
  wrap_keep_a: assert property (@(negedge sck) disable iff (cs_n)
    (load && wrap_on) |=> (rd_addr_q & ~wmask) == ($past(mem_addr) & ~wmask))
    else $error("wrapped read left its section");
  wrap_load_a: assert property (@(posedge clk) disable iff (!resetn)
    wrap_load |=> wrap_setting_bits == $past(wrap_wdata))
    else $error("wrap settings not loaded");

  read_data_c: cover property (@(posedge sck) disable iff (cs_n)
    cmd_q == sfrc_pkg::OP_READ && st_q == sfrc_pkg::S_DATA);
  crm_frame_c: cover property (@(posedge sck) disable iff (cs_n)
    st_q == sfrc_pkg::S_IDLE && crm_q ##1 st_q == sfrc_pkg::S_ADDR);
  wrap_c: cover property (@(negedge sck) disable iff (cs_n)
    load && wrap_on && ((mem_addr & wmask) == wmask));

endmodule

// ---- verilog/sfrc_pkg.sv ----
// Constants, types and operation summary for the serial flash read front end
// Operation
// - Opcode and address bits are sampled on the rising serial clock edge.
// - Data bytes leave on the falling edge, most significant bit first.
// - Address advances after every byte; only chip select rising ends the read.
// - A read arriving while the array is busy is ignored entirely.
// - Fast read 0Bh has eight don't-care dummy clocks after the address.
// - Four-lane fast reads use 4, 6 or 8 dummies, default 4; quad I/O uses 0, 2 or 4 after the mode byte.
// - Dual output read 3Bh returns two bits per clock after eight dummies.
// - Quad output read 6Bh is taken only with quad enable set.
// - Dual I/O read BBh: two-lane address, mode byte, then two-lane data.
// - Only mode bits 5:4 select the next command format.
// - Quad I/O read EBh uses four lanes and needs quad enable set.
// - Mode select 10 makes the next frame skip the opcode byte.
// - Any other mode select value returns to full opcode frames.
// - Software reset leaves continuous-read mode untouched.
// - With wrap on, quad I/O reads wrap inside the aligned section.
// - Three wrap setting bits: one disable bit and a two-bit length.
// - Wrap disable resets to one, so reads increment linearly.
// - In four-lane mode the mode byte counts toward configured dummies.
// - Continuous-read mode also works for four-lane quad I/O reads.
// - Four-lane quad I/O reads never wrap.
package sfrc_pkg;

  // ----------------------------------------------------------------------
  // Opcodes and field values
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST       = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
  localparam logic [1:0] CRM_ENTER     = 2'h2;
  localparam logic [1:0] DFIELD_RST    = 2'h0;
  localparam logic [1:0] DFIELD_6      = 2'h1;
  localparam int         ADDR_W        = 24;

  // ----------------------------------------------------------------------
  // Phase lengths in serial clocks
  // ----------------------------------------------------------------------
  localparam logic [4:0] CMD_CLKS_SPI  = 5'h08;
  localparam logic [4:0] CMD_CLKS_FL   = 5'h02;
  localparam logic [4:0] ADDR_CLKS_1   = 5'h18;
  localparam logic [4:0] ADDR_CLKS_2   = 5'h0C;
  localparam logic [4:0] ADDR_CLKS_4   = 5'h06;
  localparam logic [4:0] MODE_CLKS_2L  = 5'h04;
  localparam logic [4:0] MODE_CLKS_4L  = 5'h02;
  localparam logic [4:0] DUMMY_SPI     = 5'h08;
  localparam logic [4:0] DUMMY_QIO_SPI = 5'h04;
  localparam logic [4:0] DUMMY_4       = 5'h04;
  localparam logic [4:0] DUMMY_6       = 5'h06;
  localparam logic [4:0] DUMMY_8       = 5'h08;
  localparam logic [4:0] MODE_IN_DUMMY = 5'h04;
  localparam logic [2:0] NB_TOP        = 3'h7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_IGNORE}
    sfrc_phase_t;

  typedef struct packed {
    logic [1:0] wrap_length_field;
    logic       wrap_disable_bit;
  } sfrc_wrap_t;

  localparam sfrc_wrap_t WRAP_RST = '{wrap_length_field: 2'h0, wrap_disable_bit: 1'h1};

  typedef struct packed {
    logic       busy;
    logic       quad_enable_bit;
    logic       four_lane_command_mode;
    sfrc_wrap_t wrap;
    logic [1:0] dummy_field;
  } sfrc_cfg_t;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } sfrc_lane_drv_t;

endpackage

// ---- testbench/sfrc_host_model.sv ----
// Host controller model driving the serial read link
`timescale 1ns/100ps
module sfrc_host_model (
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      lane_o,
  output logic [3:0]      lane_oe,
  input  wire logic [3:0] lane_i
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    lane_o = 4'h0;
    lane_oe = 4'h0;
  end
  // Clock idles low; idle ticks with select high let new settings cross and clear seen_oe
  task automatic tick(input int n);
    repeat (n) begin
      #15 sck = 1'b1;
      #15 sck = 1'b0;
    end
  endtask
  task automatic start();
    tick(4);
    cs_n = 1'b0;
    #15;
  endtask
  task automatic stop();
    cs_n = 1'b1;
    lane_oe = 4'h0;
    #30;
  endtask
  // Lanes move only while the clock is low, MSB first
  task automatic shift(input logic [31:0] v, input int n, input int w, input logic drv);
    for (int i = n - 1; i >= 0; i--) begin
      if (drv)
        lane_o = 4'((v >> (i * w)) & ((1 << w) - 1));
      lane_oe = drv ? 4'((1 << w) - 1) : 4'h0;
      tick(1);
    end
  endtask
  task automatic recv(input int w, output logic [7:0] b);
    lane_oe = 4'h0;
    b = 8'h00;
    repeat (8 / w) begin
      #15 sck = 1'b1;
      b = (w == 1) ? {b[6:0], lane_i[1]} : 8'((b << w) | (lane_i & 4'((1 << w) - 1)));
      #15 sck = 1'b0;
    end
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the serial flash read front end
`timescale 1ns/100ps
module tb_top;
  localparam logic [23:0] LIN = 24'hFFFFFF;
  logic                 clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 busy = 1'b0;
  logic                 qe = 1'b0;
  logic                 flm = 1'b0;
  logic                 wld = 1'b0;
  logic                 dld = 1'b0;
  logic [1:0]           ddat = 2'h0;
  sfrc_pkg::sfrc_wrap_t wdat = 3'h1;
  sfrc_pkg::sfrc_wrap_t wsb;
  logic [1:0]           dfld;
  logic                 crm, ract, sck, cs_n, seen_oe;
  logic [3:0]           h_o, h_oe, d_o, d_oe, lane;
  logic [23:0]          maddr;
  int                   fail_count = 0;
  int                   compares = 0;
  int                   cycles = 0;
  always #2 clk = ~clk;
  // A released lane shows the inverse of its last value, never a held copy
  assign lane = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe & ~h_o);
  // Cleared by the idle clocks ahead of each frame, held once the frame ends
  always @(posedge sck)
    seen_oe <= cs_n ? 1'b0 : (seen_oe | (|d_oe));
  sfrc_host_model host (.sck(sck), .cs_n(cs_n), .lane_o(h_o), .lane_oe(h_oe), .lane_i(lane));
  sfrc_read_engine DUT (.clk(clk), .resetn(resetn), .array_busy(busy), .quad_enable_bit(qe),
    .four_lane_command_mode(flm), .wrap_load(wld), .wrap_wdata(wdat), .dummy_load(dld),
    .dummy_wdata(ddat), .wrap_setting_bits(wsb), .dummy_field(dfld),
    .continuous_read_active(crm), .read_active(ract), .sck(sck), .cs_n(cs_n),
    .data_lane_i(lane), .data_lane_o(d_o), .data_lane_oe(d_oe), .mem_addr(maddr),
    .mem_rdata(maddr[7:0] + 8'h3C));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic wrap_cfg(input sfrc_pkg::sfrc_wrap_t v);
    @(negedge clk) wdat = v;
    wld = 1'b1;
    @(negedge clk) wld = 1'b0;
    chk(wsb, v);
  endtask
  task automatic dum_cfg(input logic [1:0] v);
    @(negedge clk) ddat = v;
    dld = 1'b1;
    @(negedge clk) dld = 1'b0;
    chk(dfld, v);
  endtask
  // One frame; ow/aw are lanes for opcode/address, ow 0 skips the opcode
  task automatic rd(input logic [7:0] op, input int ow, input logic [23:0] a, input int aw,
      input int mc, input logic [7:0] m, input int dum, input int dw, input int n,
      input logic [23:0] wm, input logic ok);
    logic [7:0]  b;
    logic [23:0] ak;
    host.start();
    if (ow > 0)
      host.shift(op, 8 / ow, ow, 1'b1);
    host.shift(a, 24 / aw, aw, 1'b1);
    if (mc > 0) begin
      host.shift(m >> 4, mc / 2, aw, 1'b1);
      host.shift(0, mc / 2, aw, 1'b0);
    end
    host.shift(0, dum, 4, 1'b0);
    for (int k = 0; k < n; k++) begin
      host.recv(dw, b);
      ak = (a & ~wm) | ((a + 24'(k)) & wm);
      if (ok)
        chk(b, 8'(ak[7:0] + 8'h3C));
    end
    host.stop();
    chk(seen_oe, ok);
  endtask
  initial begin
    fork
      repeat (6) @(negedge clk);
      host.tick(3);
    join
    @(negedge clk) resetn = 1'b1;
    @(negedge clk) chk(wsb, 3'h1);
    chk(dfld, 2'h0);
    rd(8'h03, 1, 24'h0000FE, 1, 0, 8'h00, 0, 1, 3, LIN, 1'b1);
    rd(8'h0B, 1, 24'h12345E, 1, 0, 8'h00, 8, 1, 2, LIN, 1'b1);
    rd(8'h3B, 1, 24'h0200F0, 1, 0, 8'h00, 8, 2, 2, LIN, 1'b1);
    rd(8'h6B, 1, 24'h000010, 1, 0, 8'h00, 8, 4, 1, LIN, 1'b0);
    rd(8'hEB, 1, 24'h000010, 4, 2, 8'h00, 4, 4, 1, LIN, 1'b0);
    @(negedge clk) qe = 1'b1;
    rd(8'h6B, 1, 24'h00077F, 1, 0, 8'h00, 8, 4, 2, LIN, 1'b1);
    rd(8'hBB, 1, 24'h00A0FF, 2, 4, 8'hE5, 0, 2, 2, LIN, 1'b1);
    chk(crm, 1'b1);
    rd(8'hBB, 0, 24'h000333, 2, 4, 8'h00, 0, 2, 2, LIN, 1'b1);
    chk(crm, 1'b0);
    @(negedge clk) busy = 1'b1;
    rd(8'h03, 1, 24'h000100, 1, 0, 8'h00, 0, 1, 1, LIN, 1'b0);
    @(negedge clk) busy = 1'b0;
    for (int l = 0; l < 4; l++) begin
      wrap_cfg({2'(l), 1'b0});
      rd(8'hEB, 1, 24'((8<<l)-2), 4, 2, 8'h00, 4, 4, 3, 24'((8<<l)-1), 1'b1);
    end
    wrap_cfg(sfrc_pkg::WRAP_RST);
    rd(8'hEB, 1, 24'h000006, 4, 2, 8'h00, 4, 4, 3, LIN, 1'b1);
    wrap_cfg(3'h0);
    @(negedge clk) flm = 1'b1;
    for (int d = 0; d < 4; d++) begin
      dum_cfg(2'(d));
      rd(8'h0B, 4, 24'h00003E, 4, 0, 8'h00, d > 1 ? 8 : 4 + 2 * d, 4, 3, LIN, 1'b1);
      rd(8'hEB, 4, 24'h00003E, 4, 2, 8'h00, d > 1 ? 4 : 2 * d, 4, 3, LIN, 1'b1);
    end
    rd(8'hEB, 4, 24'h000050, 4, 2, 8'h20, 4, 4, 2, LIN, 1'b1);
    chk(crm, 1'b1);
    @(negedge clk) busy = 1'b1;
    rd(8'hEB, 0, 24'h000058, 4, 2, 8'h00, 4, 4, 1, LIN, 1'b0);
    @(negedge clk) busy = 1'b0;
    chk(crm, 1'b1);
    rd(8'hEB, 0, 24'h000060, 4, 2, 8'h00, 4, 4, 2, LIN, 1'b1);
    chk(crm, 1'b0);
    chk(ract, 1'b0);
    end_of_test();
  end
endmodule
